// [src/mcrs_core_regs.sv]
// programmer-visible core register set with working register banks
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 8-bit stack top: add one before push, subtract one after pop
// - reset loads stack top with 07h so first push lands at 08h
// - 16-bit external data base pointer from low and high bytes
// - 16-bit next fetch counter gives address of next instruction
// - reset forces fetch counter to 0000h
// - 8-bit main operand register takes arithmetic results
// - multiply puts its 16-bit product in second and main operand; divide puts remainder and quotient there
// - 8-bit second operand register usable as temporary storage
// - four banks of eight working registers in RAM 00h to 1Fh
// - two bank select bits pick 00h, 08h, 10h or 18h bank base
// - bank 0 active after reset
// - carry set on carry or borrow, updated by shifts
// - half carry set on carry into or borrow from upper nibble
// - user flag changes only by software writes
// - sign change flag set on sign change, product over 255, divide by 0
// - those ops clear it otherwise; clear instruction clears it
// - parity flag follows odd count of ones in main operand
// - second external data pointer selected by bit 0 of the pointer control register
// - core registers reached only by direct address 80h to FFh
module mcrs_core_regs
   import mcrs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic dir_wr,
   input wire logic [7:0] dir_addr,
   input wire logic [7:0] dir_wdata,
   output logic [7:0] dir_rdata,
   input wire logic wreg_wr,
   input wire logic [2:0] wreg_idx,
   input wire logic [7:0] wreg_wdata,
   output logic [7:0] wreg_rdata,
   input wire logic push,
   input wire logic pop,
   input wire logic [7:0] push_data,
   output logic [7:0] pop_data,
   input wire logic fetch_step,
   input wire logic fetch_load,
   input wire logic [15:0] fetch_target,
   output logic [15:0] next_fetch_counter,
   input wire logic [2:0] alu_op,
   input wire logic [7:0] alu_rhs,
   output logic [7:0] main_operand_reg,
   output logic [7:0] second_operand,
   output logic [7:0] core_flag_word,
   output logic [7:0] stack_top_pointer,
   output logic [15:0] xdata_base_pointer
);
   logic [7:0] ram_q [RAM_WORDS];
   logic [7:0] sp_q;
   logic [7:0] sp_d;
   logic [15:0] ptr0_q;
   logic [15:0] ptr1_q;
   logic [7:0] ptr_ctl_q;
   logic [7:0] ptr_mode_q;
   logic [15:0] pc_q;
   logic [7:0] acc_q;
   logic [7:0] acc_d;
   logic [7:0] b_q;
   logic [7:0] b_d;
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [7:0] rd_q;
   logic [7:0] wr_q;
   mcrs_alu_if alu_bus ();

   mcrs_flag_alu u_alu (
      .alu (alu_bus.unit)
   );

   // maps a working register index onto the active bank in RAM
   function automatic logic [7:0] bank_addr(input logic [1:0] bank,
                                            input logic [2:0] idx);
      bank_addr = {3'h0, bank, idx};
   endfunction : bank_addr

   function automatic logic is_special(input logic [7:0] addr);
      is_special = (addr >= SPECIAL_BASE);
   endfunction : is_special

   wire [1:0] bank_sel;
   wire [7:0] wreg_addr;
   wire mcrs_op_t op_in;
   wire sel_second;
   wire dir_special;
   wire wr_sp;
   wire wr_dpl;
   wire wr_dph;
   wire wr_ctl;
   wire wr_mode;
   wire wr_psw;
   wire wr_acc;
   wire wr_b;
   wire wr_ram;
   wire [15:0] active_ptr;
   wire parity;
   wire arith_op;
   wire [7:0] sp_push;

   assign bank_sel = {flags_q[FLAG_BANK_HI], flags_q[FLAG_BANK_LO]};
   assign wreg_addr = bank_addr(bank_sel, wreg_idx);
   assign op_in = mcrs_op_t'(alu_op);
   assign sel_second = ptr_ctl_q[PTR_SEL_BIT];
   assign active_ptr = sel_second ? ptr1_q : ptr0_q;
   assign dir_special = is_special(dir_addr);
   // core registers decode only in the direct special range
   assign wr_sp = dir_wr && dir_special && dir_addr == ADDR_STACK_TOP;
   assign wr_dpl = dir_wr && dir_special && dir_addr == ADDR_XBASE_LOW;
   assign wr_dph = dir_wr && dir_special && dir_addr == ADDR_XBASE_HIGH;
   assign wr_ctl = dir_wr && dir_special && dir_addr == ADDR_PTR_CONTROL;
   assign wr_mode = dir_wr && dir_special && dir_addr == ADDR_PTR_MODE;
   assign wr_psw = dir_wr && dir_special && dir_addr == ADDR_FLAG_WORD;
   assign wr_acc = dir_wr && dir_special && dir_addr == ADDR_MAIN_OPERAND;
   assign wr_b = dir_wr && dir_special && dir_addr == ADDR_SECOND_OPERAND;
   assign wr_ram = dir_wr && !dir_special;
   assign parity = ^acc_q;
   assign arith_op = (op_in == MCRS_OP_ADD) || (op_in == MCRS_OP_SUB)
                     || (op_in == MCRS_OP_MUL) || (op_in == MCRS_OP_DIV);
   assign sp_push = sp_q + 8'h01;

   assign alu_bus.op = op_in;
   assign alu_bus.lhs = acc_q;
   assign alu_bus.rhs = alu_rhs;
   assign alu_bus.carry_in = flags_q[FLAG_CARRY];
   assign alu_bus.b_in = b_q;

   // stack top: increment before a push, decrement after a pop
   always_comb
   begin
      sp_d = sp_q;
      if (wr_sp)
         sp_d = dir_wdata;
      else if (push)
         sp_d = sp_push;
      else if (pop)
         sp_d = sp_q - 8'h01;
   end

   always_comb
   begin
      acc_d = acc_q;
      b_d = b_q;
      if (op_in != MCRS_OP_NONE && op_in != MCRS_OP_CLEAR_SIGN)
         acc_d = alu_bus.result;
      else if (wr_acc)
         acc_d = dir_wdata;
      if (alu_bus.hi_valid)
         b_d = alu_bus.result_hi;
      else if (wr_b)
         b_d = dir_wdata;
   end

   always_comb
   begin
      flags_d = flags_q;
      if (wr_psw)
         flags_d = dir_wdata;
      if (op_in == MCRS_OP_ADD || op_in == MCRS_OP_SUB)
      begin
         flags_d[FLAG_CARRY] = alu_bus.carry_out;
         flags_d[FLAG_HALF] = alu_bus.half_out;
      end
      if (op_in == MCRS_OP_MUL || op_in == MCRS_OP_DIV)
         flags_d[FLAG_CARRY] = 1'b0;
      if (op_in == MCRS_OP_SHIFT)
         flags_d[FLAG_CARRY] = alu_bus.carry_out;
      if (arith_op)
         flags_d[FLAG_SIGN] = alu_bus.sign_out;
      if (op_in == MCRS_OP_CLEAR_SIGN)
         flags_d[FLAG_SIGN] = 1'b0;
      // parity is never stored from a write, it is rebuilt from acc
      flags_d[FLAG_PARITY] = ^acc_d;
   end

   always_comb
   begin
      rd_q = 8'h00;
      unique case (dir_addr)
         ADDR_STACK_TOP: rd_q = sp_q;
         ADDR_XBASE_LOW: rd_q = active_ptr[7:0];
         ADDR_XBASE_HIGH: rd_q = active_ptr[15:8];
         ADDR_PTR_CONTROL: rd_q = ptr_ctl_q;
         ADDR_PTR_MODE: rd_q = ptr_mode_q;
         ADDR_FLAG_WORD: rd_q = {flags_q[7:1], parity};
         ADDR_MAIN_OPERAND: rd_q = acc_q;
         ADDR_SECOND_OPERAND: rd_q = b_q;
         default: rd_q = dir_special ? 8'h00 : ram_q[dir_addr];
      endcase
   end

   assign wr_q = wreg_addr;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sp_q <= RST_STACK_TOP;
         pc_q <= RST_FETCH;
         acc_q <= RST_BYTE;
         b_q <= RST_BYTE;
         flags_q <= RST_BYTE;
         ptr_ctl_q <= RST_BYTE;
         ptr_mode_q <= RST_BYTE;
      end
      else
      begin
         sp_q <= sp_d;
         acc_q <= acc_d;
         b_q <= b_d;
         flags_q <= flags_d;
         if (wr_ctl)
            ptr_ctl_q <= dir_wdata;
         if (wr_mode)
            ptr_mode_q <= dir_wdata;
         if (fetch_load)
            pc_q <= fetch_target;
         else if (fetch_step)
            pc_q <= pc_q + 16'h0001;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ptr0_q <= {RST_BYTE, RST_BYTE};
         ptr1_q <= {RST_BYTE, RST_BYTE};
      end
      else
      begin
         // direct writes land in whichever pointer is selected
         if (wr_dpl && !sel_second)
            ptr0_q[7:0] <= dir_wdata;
         if (wr_dph && !sel_second)
            ptr0_q[15:8] <= dir_wdata;
         if (wr_dpl && sel_second)
            ptr1_q[7:0] <= dir_wdata;
         if (wr_dph && sel_second)
            ptr1_q[15:8] <= dir_wdata;
      end
   end

   // one shared array backs working registers, direct RAM and stack
   always_ff @(posedge mclk)
   begin
      if (wreg_wr)
         ram_q[wr_q] <= wreg_wdata;
      else if (wr_ram)
         ram_q[dir_addr] <= dir_wdata;
      else if (push)
         ram_q[sp_push] <= push_data;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         dir_rdata <= RST_BYTE;
         wreg_rdata <= RST_BYTE;
         pop_data <= RST_BYTE;
      end
      else
      begin
         dir_rdata <= rd_q;
         wreg_rdata <= ram_q[wreg_addr];
         // popped byte holds until the next pop so a slow reader still sees it
         pop_data <= pop ? ram_q[sp_q] : pop_data;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         next_fetch_counter <= RST_FETCH;
         main_operand_reg <= RST_BYTE;
         second_operand <= RST_BYTE;
         core_flag_word <= RST_BYTE;
         stack_top_pointer <= RST_STACK_TOP;
         xdata_base_pointer <= {RST_BYTE, RST_BYTE};
      end
      else
      begin
         next_fetch_counter <= fetch_load ? fetch_target
                               : (fetch_step ? pc_q + 16'h0001 : pc_q);
         main_operand_reg <= acc_d;
         second_operand <= b_d;
         core_flag_word <= flags_d;
         stack_top_pointer <= sp_d;
         // taken from the stored pointers: trails a byte write by one cycle
         xdata_base_pointer <= active_ptr;
      end
   end

   chk_stack_push_step:
   assert property (@(posedge mclk) disable iff (rst)
      (push && !pop && !wr_sp) |=> (sp_q == $past(sp_q) + 8'h01))
   else $error("stack top did not step up on push");

   chk_stack_pop_step:
   assert property (@(posedge mclk) disable iff (rst)
      (pop && !push && !wr_sp) |=> (sp_q == $past(sp_q) - 8'h01))
   else $error("stack top did not step down on pop");

   chk_parity_follow:
   assert property (@(posedge mclk) disable iff (rst)
      core_flag_word[FLAG_PARITY] == ^main_operand_reg)
   else $error("parity flag does not match main operand");

   chk_fetch_step_up:
   assert property (@(posedge mclk) disable iff (rst)
      (fetch_step && !fetch_load) |=> (pc_q == $past(pc_q) + 16'h0001))
   else $error("fetch counter did not advance");

   chk_sign_clear_op:
   assert property (@(posedge mclk) disable iff (rst)
      (op_in == MCRS_OP_CLEAR_SIGN) |=> !flags_q[FLAG_SIGN])
   else $error("clear instruction left sign change flag set");

   chk_mul_sign_set:
   assert property (@(posedge mclk) disable iff (rst)
      (op_in == MCRS_OP_MUL && (acc_q * b_q) > 16'd255)
      |=> flags_q[FLAG_SIGN])
   else $error("product over 255 did not set sign change flag");

   chk_bank_map_base:
   assert property (@(posedge mclk) disable iff (rst)
      wreg_addr[7:3] == {3'h0, bank_sel})
   else $error("working register left the active bank");

   chk_user_flag_hold:
   assert property (@(posedge mclk) disable iff (rst)
      !wr_psw |=> $stable(flags_q[FLAG_USER]))
   else $error("user flag changed without software write");
endmodule : mcrs_core_regs
`default_nettype wire

// [common/mcrs_pkg.sv]
// shared constants and types for the core register set
package mcrs_pkg;
   // special register direct addresses
   localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
   localparam logic [7:0] ADDR_XBASE_LOW = 8'h82;
   localparam logic [7:0] ADDR_XBASE_HIGH = 8'h83;
   localparam logic [7:0] ADDR_PTR_CONTROL = 8'h85;
   localparam logic [7:0] ADDR_PTR_MODE = 8'h86;
   localparam logic [7:0] ADDR_FLAG_WORD = 8'hD0;
   localparam logic [7:0] ADDR_MAIN_OPERAND = 8'hE0;
   localparam logic [7:0] ADDR_SECOND_OPERAND = 8'hF0;
   localparam logic [7:0] SPECIAL_BASE = 8'h80;
   // reset values
   localparam logic [7:0] RST_STACK_TOP = 8'h07;
   localparam logic [15:0] RST_FETCH = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_BANK = 2'h0;
   // flag word bit positions
   localparam int FLAG_CARRY = 7;
   localparam int FLAG_HALF = 6;
   localparam int FLAG_USER = 5;
   localparam int FLAG_BANK_HI = 4;
   localparam int FLAG_BANK_LO = 3;
   localparam int FLAG_SIGN = 2;
   localparam int FLAG_PARITY = 0;
   // pointer control: select bit position
   localparam int PTR_SEL_BIT = 0;
   // working register bank geometry
   localparam int BANK_REGS = 8;
   localparam int BANK_COUNT = 4;
   localparam int RAM_WORDS = 256;
   // arithmetic flag operations from the execution logic
   typedef enum logic [2:0] {
      MCRS_OP_NONE,
      MCRS_OP_ADD,
      MCRS_OP_SUB,
      MCRS_OP_MUL,
      MCRS_OP_DIV,
      MCRS_OP_SHIFT,
      MCRS_OP_CLEAR_SIGN
   } mcrs_op_t;
endpackage : mcrs_pkg

// [common/mcrs_alu_if.sv]
// carrier between the register set and its flag arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface mcrs_alu_if;
   import mcrs_pkg::*;
   mcrs_op_t op;
   logic [7:0] lhs;
   logic [7:0] rhs;
   logic carry_in;
   logic [7:0] b_in;
   logic [7:0] result;
   logic [7:0] result_hi;
   logic carry_out;
   logic half_out;
   logic sign_out;
   logic hi_valid;
   modport core (output op, lhs, rhs, carry_in, b_in,
                 input result, result_hi, carry_out, half_out, sign_out,
                 hi_valid);
   modport unit (input op, lhs, rhs, carry_in, b_in,
                 output result, result_hi, carry_out, half_out, sign_out,
                 hi_valid);
endinterface : mcrs_alu_if
`default_nettype wire

// [src/mcrs_flag_alu.sv]
// combinational arithmetic producing results and status flags
`timescale 1ns/1ps
`default_nettype none
module mcrs_flag_alu
   import mcrs_pkg::*;
(
   mcrs_alu_if.unit alu
);
   wire [8:0] add_sum;
   wire [4:0] add_nib;
   wire [8:0] sub_dif;
   wire [4:0] sub_nib;
   wire [15:0] prod;
   wire div_zero;
   wire [7:0] quot;
   wire [7:0] remd;
   assign add_sum = {1'b0, alu.lhs} + {1'b0, alu.rhs} + {8'h00, alu.carry_in};
   assign add_nib = {1'b0, alu.lhs[3:0]} + {1'b0, alu.rhs[3:0]}
                    + {4'h0, alu.carry_in};
   assign sub_dif = {1'b0, alu.lhs} - {1'b0, alu.rhs} - {8'h00, alu.carry_in};
   assign sub_nib = {1'b0, alu.lhs[3:0]} - {1'b0, alu.rhs[3:0]}
                    - {4'h0, alu.carry_in};
   // operands for multiply and divide are main and second operand
   assign prod = alu.lhs * alu.b_in;
   assign div_zero = (alu.b_in == 8'h00);
   assign quot = div_zero ? 8'hFF : alu.lhs / alu.b_in;
   assign remd = div_zero ? 8'hFF : alu.lhs % alu.b_in;

   always_comb
   begin
      alu.result = alu.lhs;
      alu.result_hi = alu.b_in;
      alu.carry_out = 1'b0;
      alu.half_out = 1'b0;
      alu.sign_out = 1'b0;
      alu.hi_valid = 1'b0;
      unique case (alu.op)
         MCRS_OP_ADD:
         begin
            alu.result = add_sum[7:0];
            alu.carry_out = add_sum[8];
            alu.half_out = add_nib[4];
            alu.sign_out = (alu.lhs[7] == alu.rhs[7])
                           && (add_sum[7] != alu.lhs[7]);
         end
         MCRS_OP_SUB:
         begin
            alu.result = sub_dif[7:0];
            alu.carry_out = sub_dif[8];
            alu.half_out = sub_nib[4];
            alu.sign_out = (alu.lhs[7] != alu.rhs[7])
                           && (sub_dif[7] != alu.lhs[7]);
         end
         MCRS_OP_MUL:
         begin
            alu.result = prod[7:0];
            alu.result_hi = prod[15:8];
            alu.hi_valid = 1'b1;
            alu.sign_out = (prod[15:8] != 8'h00);
         end
         MCRS_OP_DIV:
         begin
            alu.result = quot;
            alu.result_hi = remd;
            alu.hi_valid = 1'b1;
            alu.sign_out = div_zero;
         end
         MCRS_OP_SHIFT:
         begin
            // rotate left through carry
            alu.result = {alu.lhs[6:0], alu.carry_in};
            alu.carry_out = alu.lhs[7];
         end
         MCRS_OP_NONE, MCRS_OP_CLEAR_SIGN:
         begin
            alu.result = alu.lhs;
         end
         default:
         begin
            alu.result = alu.lhs;
         end
      endcase
   end
endmodule : mcrs_flag_alu
`default_nettype wire

// [testbench/mcrs_exec_model.sv]
// execution logic model that drives the register set request ports
`timescale 1ns/1ps
`default_nettype none
module mcrs_exec_model
   import mcrs_pkg::*;
(
   input wire logic mclk,
   output var logic dir_wr,
   output var logic [7:0] dir_addr,
   output var logic [7:0] dir_wdata,
   input wire logic [7:0] dir_rdata,
   output var logic wreg_wr,
   output var logic [2:0] wreg_idx,
   output var logic [7:0] wreg_wdata,
   input wire logic [7:0] wreg_rdata,
   output var logic push,
   output var logic pop,
   output var logic [7:0] push_data,
   input wire logic [7:0] pop_data,
   output var logic fetch_step,
   output var logic fetch_load,
   output var logic [15:0] fetch_target,
   output var logic [2:0] alu_op,
   output var logic [7:0] alu_rhs
);
   // every request is raised 1 ns after an edge and held for one edge
   initial
   begin
      {dir_wr, wreg_wr, push, pop, fetch_step, fetch_load} = 6'h00;
      dir_addr = 8'h00;
      dir_wdata = 8'h00;
      wreg_idx = 3'h0;
      wreg_wdata = 8'h00;
      push_data = 8'h00;
      fetch_target = 16'h0000;
      alu_op = MCRS_OP_NONE;
      alu_rhs = 8'h00;
   end
   task automatic dwrite(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1 dir_wr = 1'b1;
      dir_addr = a;
      dir_wdata = d;
      @(posedge mclk);
      #1 dir_wr = 1'b0;
      // data bus left inverted so stale values cannot pass for good ones
      dir_wdata = ~d;
   endtask : dwrite
   task automatic dread(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1 dir_addr = a;
      @(posedge mclk);
      #1 d = dir_rdata;
   endtask : dread
   task automatic rwrite(input logic [2:0] i, input logic [7:0] d);
      @(posedge mclk);
      #1 wreg_wr = 1'b1;
      wreg_idx = i;
      wreg_wdata = d;
      @(posedge mclk);
      #1 wreg_wr = 1'b0;
      wreg_wdata = ~d;
   endtask : rwrite
   task automatic rread(input logic [2:0] i, output logic [7:0] d);
      @(posedge mclk);
      #1 wreg_idx = i;
      @(posedge mclk);
      #1 d = wreg_rdata;
   endtask : rread
   task automatic stack(input logic is_pop, input logic [7:0] d,
                        output logic [7:0] q);
      @(posedge mclk);
      #1 push = !is_pop;
      pop = is_pop;
      push_data = d;
      @(posedge mclk);
      #1 q = pop_data;
      push = 1'b0;
      pop = 1'b0;
   endtask : stack
   task automatic fetch(input logic ld, input logic [15:0] t);
      @(posedge mclk);
      #1 fetch_step = !ld;
      fetch_load = ld;
      fetch_target = t;
      @(posedge mclk);
      #1 fetch_step = 1'b0;
      fetch_load = 1'b0;
   endtask : fetch
   task automatic arith(input mcrs_op_t op, input logic [7:0] r);
      @(posedge mclk);
      #1 alu_op = op;
      alu_rhs = r;
      @(posedge mclk);
      #1 alu_op = MCRS_OP_NONE;
   endtask : arith
endmodule : mcrs_exec_model
`default_nettype wire

// [testbench/mcu_core_register_set_tb.sv]
// self-checking bench for the core register set
`timescale 1ns/1ps
`default_nettype none
module mcu_core_register_set_tb
   import mcrs_pkg::*;
;
   logic mclk, rst, dir_wr, wreg_wr, push, pop, fetch_step, fetch_load;
   logic [7:0] dir_addr, dir_wdata, dir_rdata, wreg_wdata, wreg_rdata;
   logic [7:0] push_data, pop_data, alu_rhs, main_operand_reg;
   logic [7:0] second_operand, core_flag_word, stack_top_pointer, rd;
   logic [2:0] wreg_idx, alu_op;
   logic [15:0] fetch_target, next_fetch_counter, xdata_base_pointer;
   int n_fail = 0;
   int n_tests = 0;
   mcrs_core_regs mcrs_core_regs_i (.mclk(mclk), .rst(rst),
      .dir_wr(dir_wr), .dir_addr(dir_addr), .dir_wdata(dir_wdata),
      .dir_rdata(dir_rdata), .wreg_wr(wreg_wr), .wreg_idx(wreg_idx),
      .wreg_wdata(wreg_wdata), .wreg_rdata(wreg_rdata), .push(push),
      .pop(pop), .push_data(push_data), .pop_data(pop_data),
      .fetch_step(fetch_step), .fetch_load(fetch_load),
      .fetch_target(fetch_target),
      .next_fetch_counter(next_fetch_counter), .alu_op(alu_op),
      .alu_rhs(alu_rhs), .main_operand_reg(main_operand_reg),
      .second_operand(second_operand), .core_flag_word(core_flag_word),
      .stack_top_pointer(stack_top_pointer),
      .xdata_base_pointer(xdata_base_pointer));
   mcrs_exec_model mcrs_exec_model_i (.mclk(mclk), .dir_wr(dir_wr),
      .dir_addr(dir_addr), .dir_wdata(dir_wdata), .dir_rdata(dir_rdata),
      .wreg_wr(wreg_wr), .wreg_idx(wreg_idx), .wreg_wdata(wreg_wdata),
      .wreg_rdata(wreg_rdata), .push(push), .pop(pop),
      .push_data(push_data), .pop_data(pop_data),
      .fetch_step(fetch_step), .fetch_load(fetch_load),
      .fetch_target(fetch_target), .alu_op(alu_op), .alu_rhs(alu_rhs));
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // expected flag word; bit 1 is not ours to predict, so it stays 0
   function automatic logic [7:0] fw(input logic c, input logic h,
      input logic u, input logic [1:0] bk, input logic s,
      input logic [7:0] a);
      return {c, h, u, bk, s, 1'b0, ^a};
   endfunction : fw
   task automatic chkf(input logic [7:0] exp, input logic [7:0] m);
      chk({8'h00, core_flag_word & m & 8'hFD}, {8'h00, exp & m & 8'hFD});
   endtask : chkf
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      #500000;
      n_fail++;
      tally_and_finish();
   end
   initial
   begin
      logic [7:0] v [6];
      v = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hFE, 8'hFF};
      rst = 1'b1;
      repeat (16) @(posedge mclk);
      #1 rst = 1'b0;
      chk({8'h00, stack_top_pointer}, 16'h0007);
      chk(next_fetch_counter, 16'h0000);
      chkf(8'h00, 8'hFF);
      mcrs_exec_model_i.stack(1'b0, 8'hA5, rd);
      chk({8'h00, stack_top_pointer}, 16'h0008);
      mcrs_exec_model_i.dread(8'h08, rd);
      chk({8'h00, rd}, 16'h00A5);
      mcrs_exec_model_i.stack(1'b1, 8'h00, rd);
      chk({stack_top_pointer, rd}, 16'h07A5);
      mcrs_exec_model_i.dwrite(ADDR_XBASE_LOW, 8'h34);
      mcrs_exec_model_i.dwrite(ADDR_XBASE_HIGH, 8'h12);
      // the pointer mirror trails a write by a cycle; a read covers that
      mcrs_exec_model_i.dread(ADDR_XBASE_HIGH, rd);
      chk({8'h00, rd}, 16'h0012);
      chk(xdata_base_pointer, 16'h1234);
      mcrs_exec_model_i.dwrite(ADDR_PTR_CONTROL, 8'h01);
      mcrs_exec_model_i.dwrite(ADDR_XBASE_LOW, 8'hCD);
      mcrs_exec_model_i.dwrite(ADDR_XBASE_HIGH, 8'hAB);
      mcrs_exec_model_i.dread(ADDR_XBASE_LOW, rd);
      chk({8'h00, rd}, 16'h00CD);
      chk(xdata_base_pointer, 16'hABCD);
      mcrs_exec_model_i.dwrite(ADDR_PTR_CONTROL, 8'h00);
      mcrs_exec_model_i.dread(ADDR_XBASE_LOW, rd);
      chk({8'h00, rd}, 16'h0034);
      chk(xdata_base_pointer, 16'h1234);
      mcrs_exec_model_i.fetch(1'b0, 16'h0000);
      chk(next_fetch_counter, 16'h0001);
      mcrs_exec_model_i.fetch(1'b1, 16'hFFFE);
      mcrs_exec_model_i.fetch(1'b0, 16'h0000);
      chk(next_fetch_counter, 16'hFFFF);
      mcrs_exec_model_i.dwrite(8'h84, 8'h5A);
      mcrs_exec_model_i.dread(8'h84, rd);
      chk({8'h00, rd}, 16'h0000);
      mcrs_exec_model_i.dwrite(ADDR_SECOND_OPERAND, 8'h3C);
      mcrs_exec_model_i.dread(ADDR_SECOND_OPERAND, rd);
      chk({second_operand, rd}, 16'h3C3C);
      for (int i = 0; i < 6; i++)
      begin
         mcrs_exec_model_i.dwrite(ADDR_MAIN_OPERAND, v[i]);
         chk({main_operand_reg, 7'h00, core_flag_word[FLAG_PARITY]},
             {v[i], 7'h00, ^v[i]});
      end
      // a written parity bit of one must not stick while the parity is even
      mcrs_exec_model_i.dwrite(ADDR_FLAG_WORD, 8'h01);
      chk({15'h0000, core_flag_word[FLAG_PARITY]}, 16'h0000);
      // each bank: write through the bank, read the same cell directly
      for (int b = 0; b < 4; b++)
      begin
         mcrs_exec_model_i.dwrite(ADDR_FLAG_WORD, 8'(b << 3));
         mcrs_exec_model_i.rwrite(3'h5, 8'(8'h60 + b));
         mcrs_exec_model_i.dread(8'(b * 8 + 5), rd);
         chk({8'h00, rd}, 16'(8'h60 + b));
         mcrs_exec_model_i.dwrite(8'(b * 8 + 2), 8'(8'h90 + b));
         mcrs_exec_model_i.rread(3'h2, rd);
         chk({8'h00, rd}, 16'(8'h90 + b));
      end
      mcrs_exec_model_i.dwrite(ADDR_FLAG_WORD, 8'h20);
      mcrs_exec_model_i.dwrite(ADDR_MAIN_OPERAND, 8'h7F);
      mcrs_exec_model_i.arith(MCRS_OP_ADD, 8'h01);
      chk({8'h00, main_operand_reg}, 16'h0080);
      chkf(fw(1'b0, 1'b1, 1'b1, 2'h0, 1'b1, 8'h80), 8'hFF);
      mcrs_exec_model_i.arith(MCRS_OP_ADD, 8'h80);
      chkf(fw(1'b1, 1'b0, 1'b1, 2'h0, 1'b1, 8'h00), 8'hFF);
      mcrs_exec_model_i.dwrite(ADDR_MAIN_OPERAND, 8'h01);
      mcrs_exec_model_i.arith(MCRS_OP_ADD, 8'h01);
      chkf(fw(1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 8'h03), 8'hFF);
      mcrs_exec_model_i.dwrite(ADDR_MAIN_OPERAND, 8'h00);
      mcrs_exec_model_i.arith(MCRS_OP_SUB, 8'h01);
      chk({8'h00, main_operand_reg}, 16'h00FF);
      chkf(fw(1'b1, 1'b1, 1'b1, 2'h0, 1'b0, 8'hFF), 8'hFF);
      mcrs_exec_model_i.dwrite(ADDR_MAIN_OPERAND, 8'h10);
      mcrs_exec_model_i.dwrite(ADDR_SECOND_OPERAND, 8'h20);
      mcrs_exec_model_i.arith(MCRS_OP_MUL, 8'h00);
      chk({second_operand, main_operand_reg}, 16'h0200);
      chkf(fw(1'b0, 1'b0, 1'b1, 2'h0, 1'b1, 8'h00), 8'hA4);
      mcrs_exec_model_i.dwrite(ADDR_MAIN_OPERAND, 8'h07);
      mcrs_exec_model_i.dwrite(ADDR_SECOND_OPERAND, 8'h00);
      mcrs_exec_model_i.arith(MCRS_OP_DIV, 8'h00);
      chkf(fw(1'b0, 1'b0, 1'b1, 2'h0, 1'b1, 8'hFF), 8'hA4);
      mcrs_exec_model_i.arith(MCRS_OP_CLEAR_SIGN, 8'h00);
      chkf(fw(1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 8'hFF), 8'h24);
      mcrs_exec_model_i.dwrite(ADDR_MAIN_OPERAND, 8'h07);
      mcrs_exec_model_i.dwrite(ADDR_SECOND_OPERAND, 8'h02);
      mcrs_exec_model_i.arith(MCRS_OP_DIV, 8'h00);
      chk({second_operand, main_operand_reg}, 16'h0103);
      chkf(fw(1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 8'h03), 8'hA4);
      mcrs_exec_model_i.dwrite(ADDR_MAIN_OPERAND, 8'h81);
      mcrs_exec_model_i.arith(MCRS_OP_SHIFT, 8'h00);
      chk({8'h00, main_operand_reg}, 16'h0002);
      chkf(fw(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 8'h02), 8'hA1);
      tally_and_finish();
   end
endmodule : mcu_core_register_set_tb
`default_nettype wire
